// File: src/pir_pkg.sv
// Operation
// - Controller takes 32 interrupt lines, arbitrated over four priority levels.
// - Exactly 28 lines are wired, one peripheral instance each except line 0.
// - A peripheral sets its flag bit when its interrupt condition occurs.
// - Writing one to an enable-set bit enables that source; zeros do nothing.
// - Writing one to an enable-clear bit disables that source; zeros do nothing.
// - A source requests only while both its flag and enable are set.
// - All enabled requests of one peripheral are ORed onto one line.
// - An asserted line sets its pending bit; pending set/clear registers act on it.
// - A pending line activates toward the core only while its line enable is set.
// - Every line has a software-writable priority field, held in eight registers.
// - External unit's non-maskable request drives NMI; system units share line 0.
// - Watchdog 1, counter 2, external 3, flash 4, DMA 5, USB 6, events 7.
// - Serial units zero to five drive lines 8 to 13 in order.
// - Control timers drive lines 14 to 16, basic timers lines 17 to 21.
// - ADC 22, comparator 23, DAC 24, touch 25, AES 26, random generator 27.
package pir_pkg;

  // ==========================================================================
  // Sizes and mapping
  localparam int NUM_LINES = 32;
  localparam int NUM_WIRED = 28;
  localparam int NUM_SRC = 40;
  localparam int FLAGS_PER_SRC = 8;
  localparam int PRIO_W = 2;
  localparam int NUM_PRIO_REGS = 8;
  localparam int LINES_PER_PRIO_REG = 4;
  localparam int SRC_SYS_FIRST = 0;
  localparam int SRC_SYS_COUNT = 6;
  localparam int SRC_LINE_FIRST = 6;
  localparam int SRC_NMI = 34;
  localparam int LINE_DIRECT_FIRST = 1;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 2'h0;
  localparam logic [4:0] ID_RESET = 5'h00;

  // ==========================================================================
  // Carriers
  typedef logic [FLAGS_PER_SRC-1:0] pir_flags_t;

  typedef struct packed {
    logic valid;
    logic [4:0] id;
    logic [PRIO_W-1:0] prio;
  } pir_active_t;

endpackage

// File: src/pir_top.sv
`timescale 1ns/1ps
`default_nettype none
module pir_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Peripheral sources: condition pulses and enable set/clear strobes
  input wire logic [pir_pkg::NUM_SRC*pir_pkg::FLAGS_PER_SRC-1:0] i_cond,
  input wire logic [pir_pkg::NUM_SRC*pir_pkg::FLAGS_PER_SRC-1:0] i_flag_clear,
  input wire logic [pir_pkg::NUM_SRC*pir_pkg::FLAGS_PER_SRC-1:0] i_irq_enable_set,
  input wire logic [pir_pkg::NUM_SRC*pir_pkg::FLAGS_PER_SRC-1:0]
    i_irq_enable_clear,
  // Controller software controls
  input wire logic [pir_pkg::NUM_LINES-1:0] i_pending_set_bits,
  input wire logic [pir_pkg::NUM_LINES-1:0] i_pending_clear_bits,
  input wire logic [pir_pkg::NUM_LINES-1:0] i_line_enable_set_bits,
  input wire logic [pir_pkg::NUM_LINES-1:0] i_line_enable_clear_bits,
  input wire logic i_prio_we,
  input wire logic [2:0] i_prio_idx,
  input wire logic [4*pir_pkg::PRIO_W-1:0] i_prio_wdata,
  // Status toward software and core
  output logic [pir_pkg::NUM_SRC*pir_pkg::FLAGS_PER_SRC-1:0] o_flags,
  output logic [pir_pkg::NUM_SRC*pir_pkg::FLAGS_PER_SRC-1:0] o_enables,
  output logic [pir_pkg::NUM_LINES-1:0] o_pending,
  output logic [pir_pkg::NUM_LINES-1:0] o_line_enable,
  output logic [pir_pkg::NUM_LINES*pir_pkg::PRIO_W-1:0] o_priority_regs,
  output logic o_nmi,
  output pir_pkg::pir_active_t o_active
);

  localparam int NB = pir_pkg::NUM_SRC * pir_pkg::FLAGS_PER_SRC;
  localparam int NL = pir_pkg::NUM_LINES;
  localparam int PW = pir_pkg::PRIO_W;

  // ==========================================================================
  // Source flags and enables
  logic [NB-1:0] flag;
  logic [NB-1:0] next_flag;
  logic [NB-1:0] en;
  logic [NB-1:0] next_en;
  logic [pir_pkg::NUM_SRC-1:0] src_req;
  logic [NL-1:0] line_req;

  always_comb begin
    // Set wins over clear so a condition in the clearing cycle is kept
    next_flag = (flag & ~i_flag_clear) | i_cond;
    // Set wins when software strobes both in one cycle
    next_en = (en & ~i_irq_enable_clear) | i_irq_enable_set;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      flag <= '0;
      en <= '0;
    end else if (i_ce) begin
      flag <= next_flag;
      en <= next_en;
    end
  end

  always_comb begin
    for (int s = 0; s < pir_pkg::NUM_SRC; s++) begin
      src_req[s] = |(flag[s*pir_pkg::FLAGS_PER_SRC +: pir_pkg::FLAGS_PER_SRC]
        & en[s*pir_pkg::FLAGS_PER_SRC +: pir_pkg::FLAGS_PER_SRC]);
    end
    line_req = '0;
    line_req[0] = |src_req[pir_pkg::SRC_SYS_FIRST +: pir_pkg::SRC_SYS_COUNT];
    // Sources 6..32 map in order onto lines 1..27
    for (int l = pir_pkg::LINE_DIRECT_FIRST; l < pir_pkg::NUM_WIRED; l++) begin
      line_req[l] = src_req[pir_pkg::SRC_LINE_FIRST + l
        - pir_pkg::LINE_DIRECT_FIRST];
    end
  end

  // ==========================================================================
  // Controller pending, enable and priority state
  logic [NL-1:0] pend;
  logic [NL-1:0] next_pend;
  logic [NL-1:0] len;
  logic [NL-1:0] next_len;
  logic [NL*PW-1:0] prio;
  logic [NL*PW-1:0] next_prio;

  always_comb begin
    // A held request re-pends after clear, as a level line should
    next_pend = ((pend & ~i_pending_clear_bits) | i_pending_set_bits
      | line_req);
    next_len = (len & ~i_line_enable_clear_bits) | i_line_enable_set_bits;
    next_prio = prio;
    if (i_prio_we) begin
      next_prio[i_prio_idx*pir_pkg::LINES_PER_PRIO_REG*PW +: 4*PW] =
        i_prio_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      pend <= '0;
      len <= '0;
      prio <= {NL{pir_pkg::PRIO_RESET}};
    end else if (i_ce) begin
      pend <= next_pend;
      len <= next_len;
      prio <= next_prio;
    end
  end

  // ==========================================================================
  // Arbitration: level 0 is most urgent
  pir_pkg::pir_active_t pick;
  pir_pkg::pir_active_t next_active;
  logic next_nmi;

  always_comb begin
    pick = '0;
    pick.id = pir_pkg::ID_RESET;
    // Descending scan with <= lets the lower line win a tie
    for (int l = NL - 1; l >= 0; l--) begin
      if (pend[l] && len[l] && (!pick.valid || prio[l*PW +: PW] <= pick.prio))
      begin
        pick.valid = 1'b1;
        pick.id = 5'(l);
        pick.prio = prio[l*PW +: PW];
      end
    end
    next_active = pick;
    next_nmi = src_req[pir_pkg::SRC_NMI];
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_active <= '0;
      o_nmi <= 1'b0;
      o_flags <= '0;
      o_enables <= '0;
      o_pending <= '0;
      o_line_enable <= '0;
      o_priority_regs <= '0;
    end else if (i_ce) begin
      o_active <= next_active;
      o_nmi <= next_nmi;
      o_flags <= flag;
      o_enables <= en;
      o_pending <= pend;
      o_line_enable <= len;
      o_priority_regs <= prio;
    end
  end

endmodule // pir_top
`default_nettype wire

// File: test/pir_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module pir_src_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [8:0] i_sel,
  output logic [319:0] o_cond
);
  // Pulse follows go directly, so it cannot race the bench's falling edge
  always_comb o_cond = i_go ? 320'h1 << i_sel : 320'h0;
endmodule // pir_src_model
`default_nettype wire

// File: test/pir_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pir_asserts (
  input wire logic i_clk, i_nrst, i_prio_we, o_nmi,
  input wire logic [2:0] i_prio_idx,
  input wire logic [7:0] i_prio_wdata,
  input wire logic [31:0] i_pending_set_bits, o_pending, o_line_enable,
  input wire logic [63:0] o_priority_regs,
  input wire logic [319:0] i_cond, i_irq_enable_set, i_irq_enable_clear,
  input wire logic [319:0] o_flags, o_enables,
  input wire pir_pkg::pir_active_t o_active
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // ====
  // Copies lag the strobe by two edges
  property p_flag; i_cond[0] |-> ##2 o_flags[0]; endproperty
  a_flag: assert property (p_flag) else $error("flag lost");
  property p_eset; i_irq_enable_set[0] |-> ##2 o_enables[0]; endproperty
  a_eset: assert property (p_eset) else $error("set lost");
  property p_eclr;
    i_irq_enable_clear[0] && !i_irq_enable_set[0] |-> ##2 !o_enables[0];
  endproperty
  a_eclr: assert property (p_eclr) else $error("clear lost");
  property p_pend; o_flags[0] && o_enables[0] |-> ##[0:2] o_pending[0];
  endproperty
  a_pend: assert property (p_pend) else $error("no pending");
  property p_nmi; o_nmi == |(o_flags[279:272] & o_enables[279:272]);
  endproperty
  a_nmi: assert property (p_nmi) else $error("bad nmi");
  property p_act;
    o_active.valid |-> o_line_enable[o_active.id] && o_pending[o_active.id];
  endproperty
  a_act: assert property (p_act) else $error("bad winner");
  property p_free; $rose(o_pending[28]) |-> $past(i_pending_set_bits[28], 2);
  endproperty
  a_free: assert property (p_free) else $error("line 28 pended");
  property p_prio; i_prio_we && i_prio_idx == 3'h0 |->
    ##2 o_priority_regs[7:0] == $past(i_prio_wdata, 2); endproperty
  a_prio: assert property (p_prio) else $error("prio lost");
endmodule // pir_asserts
bind pir_top pir_asserts u_pir_asserts (.*);
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, nrst = 0, go = 0, pwe = 0, ce = 1, nmi;
  logic [8:0] sel = 0;
  logic [319:0] cond, fclr = 0, eset = 0, eclr = 0;
  logic [31:0] pset = 0, pclr = 0, lset = '1, lclr = 0, pend;
  logic [7:0] pwd = 0;
  logic [63:0] prio;
  pir_pkg::pir_active_t act;
  int err_count = 0, total_checks = 0;
  // Source beside the line it must reach
  int rows[5][2] = '{'{0,0}, '{5,0}, '{13,8}, '{21,16}, '{32,27}};
  always #2 clk = ~clk;
  pir_src_model u_pir_src_model (.i_clk(clk), .i_go(go), .i_sel(sel),
    .o_cond(cond));
  pir_top u_pir_top (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_cond(cond),
    .i_flag_clear(fclr), .i_irq_enable_set(eset), .i_irq_enable_clear(eclr),
    .i_pending_set_bits(pset), .i_pending_clear_bits(pclr),
    .i_line_enable_set_bits(lset), .i_line_enable_clear_bits(lclr),
    .i_prio_we(pwe), .i_prio_idx(3'h0), .i_prio_wdata(pwd), .o_flags(),
    .o_enables(), .o_pending(pend), .o_line_enable(), .o_priority_regs(prio),
    .o_nmi(nmi), .o_active(act));
  task automatic chk(string n, logic [63:0] s, logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic tk(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic fire(int b);
    sel = 9'(b);
    go = 1;
    tk(1);
    go = 0;
    eset = 0;
    fclr = 0;
    tk(3);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    finish_test;
  end
  initial begin
    tk(10);
    nrst = 1;
    chk("rst", prio, 64'h0);
    foreach (rows[i]) begin
      eset[rows[i][0] * 8] = 1;
      fire(rows[i][0] * 8);
      chk("line", pend, 32'h1 << rows[i][1]);
      chk("win", act, {1'b1, 5'(rows[i][1]), 2'h0});
      fclr = '1;
      eclr = '1;
      tk(1);
      fclr = 0;
      eclr = 0;
      pclr = '1;
      tk(1);
      pclr = 0;
      tk(3);
      chk("clr", pend, 32'h0);
      $display("row %0d done", i);
    end
    fire(9'h030);
    chk("masked", pend, 32'h0);
    fclr = '1;
    eset[272] = 1;
    fire(9'h110);
    chk("nmi", {nmi, pend}, 33'h100000000);
    pwd = 8'h04;
    pwe = 1;
    pset = 32'h10000006;
    tk(1);
    pwe = 0;
    pset = 0;
    tk(3);
    chk("prio", {act, prio[7:0]}, {1'b1, 5'h02, 2'h0, 8'h04});
    $display("prio test done");
    // Mid-run reset drops the held nmi flag and every pending line
    nrst = 0;
    tk(2);
    chk("rst nmi", {nmi, pend}, 33'h0);
    chk("rst act", act, 8'h00);
    nrst = 1;
    tk(1);
    chk("rel nmi", {nmi, pend}, 33'h0);
    tk(2);
    $display("reset test done");
    // A pending line whose line enable is cleared must not win
    lset = 0;
    lclr = 32'h8;
    tk(1);
    lclr = 0;
    pset = 32'h8;
    tk(1);
    pset = 0;
    tk(3);
    chk("off pend", pend, 32'h8);
    chk("off act", act, 8'h00);
    $display("line enable test done");
    // Strobes while the clock enable is low are ignored
    ce = 0;
    pset = 32'h10;
    tk(1);
    pset = 0;
    tk(1);
    ce = 1;
    tk(2);
    chk("frozen", pend, 32'h8);
    $display("hand tests done");
    finish_test;
  end
endmodule // testbench
`default_nettype wire
